// ==== hdl/reset_wake_state_init.v ====
// Reset and wake-up state loader for the core special registers, with an AXI4-Lite slave.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "reset_wake_state_init_regs.vh"

// How it works
// - External reset awake: pc zero, status top three cleared
// - External reset asleep: pc zero, status 0001_0uuu
// - Interrupt wake: pc plus one, power control kept
// - Interrupt wake with enable: then jump to vector
// - Brown-out clears power bit zero, sets bits three and two to 01, keeps bit one
// - Interrupt wake sets at least one flag bit
// - Analog upper select all ones on reset only
// - Alternate serial register visible only in mode 1001
// - Global interrupt enable cleared on every reset
module reset_wake_state_init #(
  parameter PC_WIDTH = 13
) (
  input wire aclk,
  input wire aresetn,
  input wire power_on_evt,
  input wire brown_out_evt,
  input wire watchdog_timer_reset_evt,
  input wire external_reset_pin_evt,
  input wire watchdog_timer_wake_evt,
  input wire irq_wake_evt,
  input wire asleep,
  input wire [PC_WIDTH-1:0] current_pc,
  input wire [7:0] irq_wake_control_src,
  input wire [7:0] irq_wake_periph_src,
  output reg pc_load,
  output reg [PC_WIDTH-1:0] pc_value,
  output wire [7:0] status_value,
  output wire [3:0] power_control_value,
  output wire [7:0] irq_control_value,
  output wire [7:0] peripheral_irq_flags_1_value,
  output wire [7:0] analog_select_upper_value,
  output wire alt_serial_visible,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  reg [7:0] status_reg, status_next;
  reg [3:0] power_control_reg, power_control_next;
  reg [7:0] irq_control_reg, irq_control_next;
  reg [7:0] periph_flags_reg, periph_flags_next;
  reg [7:0] analog_upper_reg, analog_upper_next;
  reg [3:0] serial_mode_reg, serial_mode_next;
  reg [7:0] alt_serial_reg, alt_serial_next;
  reg [3:0] cause_reg, cause_next;
  reg vector_pending_reg, vector_pending_next;
  reg [PC_WIDTH-1:0] pc_next;
  reg pc_load_next;

  reg [7:0] aw_addr_reg;
  reg aw_held_reg;
  reg [7:0] w_data_reg;
  reg w_strb0_reg;
  reg w_held_reg;

  // Returns true for offsets that hold a register, writable or not.
  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr[1:0] == 2'b00) && (addr <= `OFS_LAST_CAUSE);
    end
  endfunction

  assign status_value = status_reg;
  assign power_control_value = power_control_reg;
  assign irq_control_value = irq_control_reg;
  assign peripheral_irq_flags_1_value = periph_flags_reg;
  assign analog_select_upper_value = analog_upper_reg;
  assign alt_serial_visible = (serial_mode_reg == `SERIAL_ALT_MODE);

  ////////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are taken in either order, then one response.

  wire wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 8'h00;
      w_strb0_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_strb0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read channel: one read at a time, answered the cycle after it is taken.

  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      case (s_axi_araddr)
        `OFS_STATUS: s_axi_rdata <= {24'h00_0000, status_reg};
        `OFS_POWER_CONTROL: s_axi_rdata <= {28'h000_0000, power_control_reg};
        `OFS_IRQ_CONTROL: s_axi_rdata <= {24'h00_0000, irq_control_reg};
        `OFS_PERIPH_FLAGS: s_axi_rdata <= {24'h00_0000, periph_flags_reg};
        `OFS_ANALOG_UPPER: s_axi_rdata <= {24'h00_0000, analog_upper_reg};
        `OFS_SERIAL_MODE: s_axi_rdata <= {28'h000_0000, serial_mode_reg};
        `OFS_ALT_SERIAL: s_axi_rdata <= alt_serial_visible ?
          {24'h00_0000, alt_serial_reg} : 32'h0000_0000;
        `OFS_PC_VALUE: s_axi_rdata <= {{(32-PC_WIDTH){1'b0}}, pc_value};
        `OFS_LAST_CAUSE: s_axi_rdata <= {28'h000_0000, cause_reg};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State loading. Software writes are applied first and the reset or wake event
  // afterwards, so an event in the same cycle as a write wins, except that an interrupt wake ORs its sources into a written irq control or flag value.

  always @* begin
    status_next = status_reg;
    power_control_next = power_control_reg;
    irq_control_next = irq_control_reg;
    periph_flags_next = periph_flags_reg;
    analog_upper_next = analog_upper_reg;
    serial_mode_next = serial_mode_reg;
    alt_serial_next = alt_serial_reg;
    cause_next = cause_reg;
    vector_pending_next = 1'b0;
    pc_next = pc_value;
    pc_load_next = 1'b0;

    if (wr_fire && w_strb0_reg) begin
      case (aw_addr_reg)
        `OFS_STATUS: status_next = w_data_reg;
        `OFS_POWER_CONTROL: power_control_next = w_data_reg[3:0];
        `OFS_IRQ_CONTROL: irq_control_next = w_data_reg;
        `OFS_PERIPH_FLAGS: periph_flags_next = w_data_reg;
        `OFS_ANALOG_UPPER: analog_upper_next = w_data_reg;
        `OFS_SERIAL_MODE: serial_mode_next = w_data_reg[3:0];
        `OFS_ALT_SERIAL: begin
          if (alt_serial_visible) begin
            alt_serial_next = w_data_reg;
          end
        end
        default: begin
        end
      endcase
    end

    // The second step of an interrupt wake: the instruction after the sleep
    // has been fetched at pc plus one, now branch to the vector.
    if (vector_pending_reg) begin
      pc_next = `PC_IRQ_VECTOR;
      pc_load_next = 1'b1;
    end

    if (power_on_evt || brown_out_evt || watchdog_timer_reset_evt || external_reset_pin_evt) begin
      pc_next = `PC_RESET_ADDR;
      pc_load_next = 1'b1;
      irq_control_next = {7'b000_0000, irq_control_reg[0]};
      periph_flags_next = 8'h00;
      analog_upper_next = `ANALOG_UPPER_RESET;
      // The event beats a software write in the same cycle, so start from the register.
      power_control_next = power_control_reg;
      power_control_next[`POWER_CONTROL_REG_TOP_BIT] = 1'b0;
      if (power_on_evt) begin
        cause_next = `CAUSE_POR;
        status_next = {5'b0_0011, 3'b000};
        power_control_next = {3'b010, power_control_reg[`POWER_CONTROL_REG_BOR_BIT]};
      end else if (brown_out_evt) begin
        cause_next = `CAUSE_BOR;
        status_next = {5'b0_0011, status_reg[2:0]};
        power_control_next = {2'b01, power_control_reg[1], 1'b0};
      end else if (watchdog_timer_reset_evt) begin
        cause_next = `CAUSE_WDT_RESET;
        status_next = {4'b0000, status_reg[3:0]};
      end else if (asleep) begin
        cause_next = `CAUSE_EXT_SLEEP;
        status_next = {5'b0_0010, status_reg[2:0]};
      end else begin
        cause_next = `CAUSE_EXT_NORMAL;
        status_next = {3'b000, status_reg[4:0]};
      end
    end else if (watchdog_timer_wake_evt) begin
      cause_next = `CAUSE_WDT_WAKE;
      pc_next = current_pc + 1'b1;
      pc_load_next = 1'b1;
      status_next = status_reg;
      power_control_next = power_control_reg;
      status_next[`STATUS_TO_BIT] = 1'b0;
      status_next[`STATUS_PD_BIT] = 1'b0;
    end else if (irq_wake_evt) begin
      cause_next = `CAUSE_IRQ_WAKE;
      pc_next = current_pc + 1'b1;
      pc_load_next = 1'b1;
      status_next = status_reg;
      power_control_next = power_control_reg;
      status_next[`STATUS_TO_BIT] = 1'b1;
      status_next[`STATUS_PD_BIT] = 1'b0;
      irq_control_next = irq_control_next | irq_wake_control_src;
      periph_flags_next = periph_flags_next | irq_wake_periph_src;
      // A wake with no source given still records one, so the cause is visible.
      if (irq_wake_control_src == 8'h00 && irq_wake_periph_src == 8'h00) begin
        irq_control_next[`INTF_BIT] = 1'b1;
      end
      vector_pending_next = irq_control_reg[`GIE_BIT];
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= 8'h18;
      power_control_reg <= 4'h4;
      irq_control_reg <= 8'h00;
      periph_flags_reg <= 8'h00;
      analog_upper_reg <= `ANALOG_UPPER_RESET;
      serial_mode_reg <= 4'h0;
      alt_serial_reg <= 8'h00;
      cause_reg <= `CAUSE_NONE;
      vector_pending_reg <= 1'b0;
      pc_value <= `PC_RESET_ADDR;
      pc_load <= 1'b0;
    end else begin
      status_reg <= status_next;
      power_control_reg <= power_control_next;
      irq_control_reg <= irq_control_next;
      periph_flags_reg <= periph_flags_next;
      analog_upper_reg <= analog_upper_next;
      serial_mode_reg <= serial_mode_next;
      alt_serial_reg <= alt_serial_next;
      cause_reg <= cause_next;
      vector_pending_reg <= vector_pending_next;
      pc_value <= pc_next;
      pc_load <= pc_load_next;
    end
  end

endmodule // reset_wake_state_init

// ==== hdl/reset_wake_state_init_regs.vh ====
// Offsets, field positions, reset values and vector constants of the reset and wake block.
`ifndef RESET_WAKE_STATE_INIT_REGS_VH
`define RESET_WAKE_STATE_INIT_REGS_VH

`define OFS_STATUS 8'h00
`define OFS_POWER_CONTROL 8'h04
`define OFS_IRQ_CONTROL 8'h08
`define OFS_PERIPH_FLAGS 8'h0C
`define OFS_ANALOG_UPPER 8'h10
`define OFS_SERIAL_MODE 8'h14
`define OFS_ALT_SERIAL 8'h18
`define OFS_PC_VALUE 8'h1C
`define OFS_LAST_CAUSE 8'h20

`define PC_RESET_ADDR 13'h0000
`define PC_IRQ_VECTOR 13'h0004
`define ANALOG_UPPER_RESET 8'hFF
`define SERIAL_ALT_MODE 4'h9
`define GIE_BIT 7
`define INTF_BIT 1
`define STATUS_TO_BIT 4
`define STATUS_PD_BIT 3
`define POWER_CONTROL_REG_BOR_BIT 0
`define POWER_CONTROL_REG_TOP_BIT 3

`define CAUSE_NONE 4'h0
`define CAUSE_POR 4'h1
`define CAUSE_BOR 4'h2
`define CAUSE_WDT_RESET 4'h3
`define CAUSE_EXT_NORMAL 4'h4
`define CAUSE_EXT_SLEEP 4'h5
`define CAUSE_WDT_WAKE 4'h6
`define CAUSE_IRQ_WAKE 4'h7

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ==== test/reset_wake_state_init_checker.sv ====
// Concurrent checks of the reset and wake state loader.
`timescale 1ns/1ps
module reset_wake_state_init_checker #(parameter PC_WIDTH = 13) (
  input wire aclk,
  input wire aresetn,
  input wire power_on_evt,
  input wire brown_out_evt,
  input wire watchdog_timer_reset_evt,
  input wire external_reset_pin_evt,
  input wire watchdog_timer_wake_evt,
  input wire irq_wake_evt,
  input wire asleep,
  input wire [PC_WIDTH-1:0] current_pc,
  input wire pc_load,
  input wire [PC_WIDTH-1:0] pc_value,
  input wire [7:0] status_value,
  input wire [3:0] power_control_value,
  input wire [7:0] irq_control_value,
  input wire [7:0] peripheral_irq_flags_1_value,
  input wire [7:0] analog_select_upper_value
);
  // Higher priority causes mask the lower ones, so each check sees one winner.
  wire rst_any = power_on_evt | brown_out_evt | watchdog_timer_reset_evt | external_reset_pin_evt;
  wire ext_only = external_reset_pin_evt &
    ~(power_on_evt | brown_out_evt | watchdog_timer_reset_evt);
  wire wake_any = watchdog_timer_wake_evt | irq_wake_evt;
  wire irq_only = irq_wake_evt & ~rst_any & ~watchdog_timer_wake_evt;
  wire bor_win = brown_out_evt & ~power_on_evt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_ext_awake;
    ext_only && !asleep |=> status_value[7:5] == 3'h0 &&
      status_value[4:0] == $past(status_value[4:0]) && !power_control_value[3];
  endproperty
  a_ext_awake: assert property (p_ext_awake) else $error("awake pin reset state wrong");
  property p_ext_sleep;
    ext_only && asleep |=> status_value[7:3] == 5'h02 &&
      status_value[2:0] == $past(status_value[2:0]) && !power_control_value[3];
  endproperty
  a_ext_sleep: assert property (p_ext_sleep) else $error("asleep pin reset state wrong");
  property p_wake;
    irq_only |=> pc_load && pc_value == $past(current_pc) + 1'b1 &&
      $stable(power_control_value) && status_value[4:3] == 2'h2;
  endproperty
  a_wake: assert property (p_wake) else $error("interrupt wake state wrong");
  property p_vector;
    irq_only && irq_control_value[7] ##1 !(rst_any | wake_any) |=>
      pc_load && pc_value == 13'h0004;
  endproperty
  a_vector: assert property (p_vector) else $error("vector load missing");
  property p_bor;
    bor_win |=> !power_control_value[0];
  endproperty
  a_bor: assert property (p_bor) else $error("brown-out bit not cleared");
  property p_bit0_kept;
    rst_any && !bor_win |=> $stable(power_control_value[0]);
  endproperty
  a_bit0_kept: assert property (p_bit0_kept) else $error("power bit zero changed");
  property p_flag;
    irq_only |=> |{irq_control_value[2:0], peripheral_irq_flags_1_value};
  endproperty
  a_flag: assert property (p_flag) else $error("no wake flag set");
  property p_analog;
    rst_any |=> analog_select_upper_value == 8'hFF;
  endproperty
  a_analog: assert property (p_analog) else $error("analog select not all ones");
  property p_pc_zero;
    rst_any |=> pc_load && pc_value == 13'h0000;
  endproperty
  a_pc_zero: assert property (p_pc_zero) else $error("reset pc load wrong");
  property p_gie;
    rst_any |=> !irq_control_value[7];
  endproperty
  a_gie: assert property (p_gie) else $error("global enable kept over reset");
  c_vec: cover property (irq_only && irq_control_value[7]);
  c_sleep: cover property (ext_only && asleep);
  c_bor: cover property (bor_win);
endmodule // reset_wake_state_init_checker

bind reset_wake_state_init reset_wake_state_init_checker #(.PC_WIDTH(PC_WIDTH)) chk_i (.aclk,
  .aresetn, .power_on_evt, .brown_out_evt, .watchdog_timer_reset_evt, .external_reset_pin_evt,
  .watchdog_timer_wake_evt, .irq_wake_evt, .asleep, .current_pc, .pc_load, .pc_value,
  .status_value, .power_control_value, .irq_control_value, .peripheral_irq_flags_1_value,
  .analog_select_upper_value);

// ==== test/test_reset_wake_state_init.sv ====
// Self-checking bench for the reset and wake state loader.
`timescale 1ns/1ps
`include "reset_wake_state_init_regs.vh"
module test_reset_wake_state_init;
  logic aclk = 0, aresetn = 0;
  logic power_on_evt, brown_out_evt, watchdog_timer_reset_evt, external_reset_pin_evt;
  logic watchdog_timer_wake_evt, irq_wake_evt, asleep, pc_load, alt_serial_visible;
  logic [6:0] evs = 7'h00;
  logic [12:0] current_pc = 13'h0123, pc_value;
  logic [7:0] irq_wake_control_src = 8'h00, irq_wake_periph_src = 8'h00, status_value;
  logic [7:0] irq_control_value, peripheral_irq_flags_1_value, analog_select_upper_value;
  logic [3:0] power_control_value, s_axi_wstrb = 4'hF;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int fail_count = 0, total_checks = 0;
  // Row: event bits, status, power control, pc, analog select, all as expected after the event.
  logic [39:0] rows [7] = '{{7'h40, 8'h18, 4'h5, 13'h0000, 8'hFF},
    {7'h20, 8'h1A, 4'h6, 13'h0000, 8'hFF}, {7'h10, 8'h0A, 4'h7, 13'h0000, 8'hFF},
    {7'h08, 8'h0A, 4'h7, 13'h0000, 8'hFF}, {7'h09, 8'h12, 4'h7, 13'h0000, 8'hFF},
    {7'h05, 8'hE2, 4'hF, 13'h0124, 8'h00}, {7'h03, 8'hF2, 4'hF, 13'h0124, 8'h00}};
  assign {power_on_evt, brown_out_evt, watchdog_timer_reset_evt, external_reset_pin_evt,
    watchdog_timer_wake_evt, irq_wake_evt, asleep} = evs;
  reset_wake_state_init uut (.aclk(aclk), .aresetn(aresetn), .power_on_evt(power_on_evt),
    .brown_out_evt(brown_out_evt), .watchdog_timer_reset_evt(watchdog_timer_reset_evt),
    .external_reset_pin_evt(external_reset_pin_evt),
    .watchdog_timer_wake_evt(watchdog_timer_wake_evt), .irq_wake_evt(irq_wake_evt),
    .asleep(asleep), .current_pc(current_pc), .irq_wake_control_src(irq_wake_control_src),
    .irq_wake_periph_src(irq_wake_periph_src), .pc_load(pc_load), .pc_value(pc_value),
    .status_value(status_value), .power_control_value(power_control_value),
    .irq_control_value(irq_control_value),
    .peripheral_irq_flags_1_value(peripheral_irq_flags_1_value),
    .analog_select_upper_value(analog_select_upper_value),
    .alt_serial_visible(alt_serial_visible), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  always #2.5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  // Events are one-cycle pulses; the result is looked at just after the edge that takes them.
  task automatic ev(input logic [6:0] v);
    @(posedge aclk);
    evs <= v;
    @(posedge aclk);
    evs <= 7'h00;
    #1;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2000) @(posedge aclk);
    fail_count++;
    stop_test;
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    foreach (rows[i]) begin
      axw(`OFS_STATUS, 32'h0000_00EA);
      chk("write resp", `RESP_OKAY, rs);
      axw(`OFS_POWER_CONTROL, 32'h0000_000F);
      axw(`OFS_IRQ_CONTROL, 32'h0000_0000);
      axw(`OFS_ANALOG_UPPER, 32'h0000_0000);
      ev(rows[i][39:33]);
      chk("pc_load", 1, pc_load);
      chk("pc", rows[i][20:8], pc_value);
      chk("status", rows[i][32:25], status_value);
      chk("power", rows[i][24:21], power_control_value);
      chk("analog", rows[i][7:0], analog_select_upper_value);
    end
    chk("wake flag", 8'h02, irq_control_value);
    axw(`OFS_IRQ_CONTROL, 32'h0000_0080);
    irq_wake_periph_src <= 8'h04;
    ev(7'h03);
    chk("wake pc", 13'h0124, pc_value);
    chk("flags", 8'h04, peripheral_irq_flags_1_value);
    chk("irq ctrl", 8'h80, irq_control_value);
    @(posedge aclk);
    #1;
    chk("vector load", 1, pc_load);
    chk("vector pc", 13'h0004, pc_value);
    @(posedge aclk);
    #1;
    chk("load end", 0, pc_load);
    ev(7'h08);
    chk("enable", 0, irq_control_value[7]);
    axw(`OFS_POWER_CONTROL, 32'h0000_000F);
    // The write and the pin reset land on the same edge; the reset must win.
    fork
      axw(`OFS_POWER_CONTROL, 32'h0000_0000);
      begin
        @(posedge aclk);
        ev(7'h08);
      end
    join
    chk("power race", 4'h7, power_control_value);
    axw(`OFS_SERIAL_MODE, 32'h0000_0009);
    axw(`OFS_ALT_SERIAL, 32'h0000_005A);
    axr(`OFS_ALT_SERIAL);
    chk("alt read", 32'h0000_005A, rd);
    chk("alt shown", 1, alt_serial_visible);
    axw(`OFS_SERIAL_MODE, 32'h0000_0008);
    axr(`OFS_ALT_SERIAL);
    chk("alt hidden", 32'h0000_0000, rd);
    chk("alt shown", 0, alt_serial_visible);
    axw(`OFS_ALT_SERIAL, 32'h0000_0033);
    axw(`OFS_SERIAL_MODE, 32'h0000_0009);
    axr(`OFS_ALT_SERIAL);
    chk("alt kept", 32'h0000_005A, rd);
    s_axi_wstrb <= 4'h0;
    axw(`OFS_ANALOG_UPPER, 32'h0000_0011);
    s_axi_wstrb <= 4'hF;
    axr(`OFS_ANALOG_UPPER);
    chk("masked write", 32'h0000_00FF, rd);
    axr(8'h24);
    chk("unmapped", `RESP_SLVERR, rs);
    chk("unmapped data", 32'h0000_0000, rd);
    axw(8'h24, 32'h0000_0001);
    chk("unmapped write", `RESP_SLVERR, rs);
    ev(7'h04);
    axw(`OFS_IRQ_CONTROL, 32'h0000_0080);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    #1;
    chk("reset enable", 0, irq_control_value[7]);
    chk("reset pc", 13'h0000, pc_value);
    chk("reset status", 8'h18, status_value);
    chk("reset load", 0, pc_load);
    stop_test;
  end
endmodule // test_reset_wake_state_init
